// ### wcs_pkg.sv
// Shared constants for the writable microcode store block.
package wcs_pkg;

  // ----------------------------------------------------------------
  // Clock and fetch timing
  // ----------------------------------------------------------------
  // Period of clk in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  // Longest allowed time from micro-address to valid microword.
  localparam int FETCH_ACCESS_NS = 140;
  // Longest time in whole cycles, rounded down.
  localparam int FETCH_ACCESS_CYCLES = FETCH_ACCESS_NS / CLK_PERIOD_NS;
  // Processor microcycle that the fetch must fit in.
  localparam int MICROCYCLE_NS = 196;
  // Cycles from micro-address to microword output in this design.
  localparam int FETCH_LATENCY = 2;

  // ----------------------------------------------------------------
  // Store geometry
  // ----------------------------------------------------------------
  localparam int STORE_WORDS = 256;
  localparam int WORD_BITS = 24;
  localparam int ADDR_BITS = 8;
  localparam int MICRO_ADDR_BITS = 10;
  localparam int IO_BITS = 16;
  localparam int CODE_BITS = 6;
  // Largest DMA block for one module, in 16-bit words.
  localparam int DMA_BLOCK_MAX = 512;

  // ----------------------------------------------------------------
  // Positions in the synchronised pin vector
  // ----------------------------------------------------------------
  localparam int PIN_PRESET = 0;
  localparam int PIN_SETFLAG = 1;
  localparam int PIN_CLRFLAG = 2;
  localparam int PIN_SETCTL = 3;
  localparam int PIN_CLRCTL = 4;
  localparam int PIN_OUT = 5;
  localparam int PIN_IN = 6;
  localparam int PIN_T3 = 7;
  localparam int PIN_T5 = 8;
  localparam int PIN_SEL_LSB = 9;
  localparam int PIN_BUS_LSB = 15;
  localparam int PIN_WIDTH = 31;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // Configuration fields.
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_OVERRIDE_BIT = 2;
  localparam int CFG_CODE_LSB = 8;
  // Status fields.
  localparam int ST_DIR = 0;
  localparam int ST_TOGGLE = 1;
  localparam int ST_CONTROL = 2;
  localparam int ST_REQUEST = 3;
  localparam int ST_PENDING = 4;
  // Reset values.
  localparam logic [1:0] SELECTOR_RESET = 2'h0;
  localparam logic [5:0] SELECT_CODE_RESET = 6'h15;

endpackage : wcs_pkg

// ### writable_store_ram.sv
// Dual-port microword array: fetch read port and I/O read/write port.
`timescale 1ns/1ns

module writable_store_ram #(
  parameter int WORDS = wcs_pkg::STORE_WORDS,
  parameter int WIDTH = wcs_pkg::WORD_BITS,
  parameter int ABITS = wcs_pkg::ADDR_BITS
) (
  input wire logic clk,
  input wire logic [ABITS-1:0] fetchAddress,
  output logic [WIDTH-1:0] fetchWord,
  input wire logic [ABITS-1:0] ioAddress,
  input wire logic ioWrite,
  input wire logic [WIDTH-1:0] ioWriteWord,
  output logic [WIDTH-1:0] ioReadWord
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // store array
  // The array has no reset, like the bipolar parts it stands for.
  logic [WIDTH-1:0] store [WORDS];

  // Write port, used only by the I/O load path.
  always_ff @(posedge clk) begin
    if (ioWrite) begin
      store[ioAddress] <= ioWriteWord;
    end
  end

  // Registered fetch read, one cycle after the address.
  always_ff @(posedge clk) begin
    fetchWord <= store[fetchAddress];
  end

  // Registered readback for the I/O bus.
  always_ff @(posedge clk) begin
    ioReadWord <= store[ioAddress];
  end

endmodule : writable_store_ram

// ### writable_store.sv
// Writable microcode store: fetch port, I/O bus load port, APB setup.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns

module writable_store (
  input wire logic clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fetch port toward the microsequencer.
  input wire logic [9:0] microAddress,
  output logic [23:0] microwordLines,
  output logic moduleZeroInhibit,
  // I/O bus pins from the processor.
  input wire logic powerOnIoPreset,
  input wire logic setFlagStrobe,
  input wire logic clearFlagStrobe,
  input wire logic setControlStrobe,
  input wire logic clearControlStrobe,
  input wire logic outputStrobe,
  input wire logic inputStrobe,
  input wire logic phaseT3,
  input wire logic phaseT5,
  input wire logic [5:0] ioSelectCode,
  input wire logic [15:0] ioBusIn,
  output logic [15:0] ioBusOut,
  output logic ioBusDrive,
  output logic serviceRequest
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Raw pin vector in package order.
  logic [wcs_pkg::PIN_WIDTH-1:0] pinRaw;
  // Three stages; a bit counts once stages two and three agree.
  logic [wcs_pkg::PIN_WIDTH-1:0] syncA;
  logic [wcs_pkg::PIN_WIDTH-1:0] syncB;
  logic [wcs_pkg::PIN_WIDTH-1:0] syncC;
  // Filtered pin levels, and last cycle's copy for edges.
  logic [wcs_pkg::PIN_WIDTH-1:0] pin;
  logic [wcs_pkg::PIN_WIDTH-1:0] pinPrev;

  assign pinRaw = {ioBusIn, ioSelectCode, phaseT5, phaseT3, inputStrobe,
                   outputStrobe, clearControlStrobe, setControlStrobe,
                   clearFlagStrobe, setFlagStrobe, powerOnIoPreset};

  // Each pin bit gets its own three-stage chain and agreement filter.
  // Stage A feeds only stage B, so nothing looks at a metastable bit.
  genvar g;
  generate
    for (g = 0; g < wcs_pkg::PIN_WIDTH; g++) begin : gSync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
          syncC[g] <= 1'b0;
          pin[g] <= 1'b0;
          pinPrev[g] <= 1'b0;
        end else begin
          syncA[g] <= pinRaw[g];
          syncB[g] <= syncA[g];
          syncC[g] <= syncB[g];
          // Pulses shorter than two cycles never pass the filter.
          if (syncB[g] == syncC[g]) begin
            pin[g] <= syncC[g];
          end
          pinPrev[g] <= pin[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB configuration and status
  // ----------------------------------------------------------------
  // Module-number selector, 0 to 3.
  logic [1:0] selector;
  // Module-zero override switch.
  logic moduleZeroOverride;
  // Select code this module answers on the I/O bus.
  logic [5:0] selectCode;
  // Flip-flops of the I/O port.
  logic directionFf;
  logic toggleFf;
  logic controlFf;
  logic serviceRequestFf;
  logic writePending;
  // Access phase of an APB transfer that completes this cycle.
  logic apbDone;
  logic apbSetup;
  logic [31:0] statusWord;
  logic [31:0] configWord;

  assign apbSetup = psel && !penable;
  assign apbDone = psel && penable && pready;
  assign statusWord = {27'h0000000, writePending, serviceRequestFf,
                       controlFf, toggleFf, directionFf};
  assign configWord = {18'h00000, selectCode, 5'h00, moduleZeroOverride,
                       selector};

  // Ready rises for one cycle after each setup cycle, so every
  // transfer has exactly one access cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apbSetup;
      if (apbSetup) begin
        // Unmapped offsets answer zero with an error.
        case (paddr)
          wcs_pkg::CONFIG_OFFSET: begin
            prdata <= pwrite ? 32'h00000000 : configWord;
            pslverr <= 1'b0;
          end
          wcs_pkg::STATUS_OFFSET: begin
            prdata <= pwrite ? 32'h00000000 : statusWord;
            pslverr <= 1'b0;
          end
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Configuration register write; status is read only.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selector <= wcs_pkg::SELECTOR_RESET;
      moduleZeroOverride <= 1'b0;
      selectCode <= wcs_pkg::SELECT_CODE_RESET;
    end else if (apbDone && pwrite && paddr == wcs_pkg::CONFIG_OFFSET) begin
      selector <= pwdata[wcs_pkg::CFG_SEL_LSB +: 2];
      moduleZeroOverride <= pwdata[wcs_pkg::CFG_OVERRIDE_BIT];
      selectCode <= pwdata[wcs_pkg::CFG_CODE_LSB +: wcs_pkg::CODE_BITS];
    end
  end

  // ----------------------------------------------------------------
  // Fetch port
  // ----------------------------------------------------------------
  logic fetchHit;
  logic fetchHitDelayed;
  logic [23:0] fetchWord;
  logic inhibitNext;

  // module decode
  // Selector zero answers only with the override on, since the
  // built-in store owns module zero otherwise.
  assign fetchHit = microAddress[9:8] == selector
                    && (selector != 2'h0 || moduleZeroOverride);
  assign inhibitNext = moduleZeroOverride && selector == 2'h0;

  // two-cycle fetch
  // The lines are or-tied with the built-in store, so idle means zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchHitDelayed <= 1'b0;
      microwordLines <= 24'h000000;
      moduleZeroInhibit <= 1'b0;
    end else begin
      fetchHitDelayed <= fetchHit;
      microwordLines <= fetchHitDelayed ? fetchWord : 24'h000000;
      moduleZeroInhibit <= inhibitNext;
    end
  end

  // ----------------------------------------------------------------
  // I/O strobe events
  // ----------------------------------------------------------------
  logic codeMatch;
  logic t3Pulse;
  logic t5Pulse;
  logic presetEvent;
  logic setFlagEvent;
  logic clearFlagEvent;
  logic setControlEvent;
  logic clearControlEvent;
  logic outputActive;
  logic inputActive;
  logic strobeEvent;

  // foreign codes
  // Every event below except preset needs our own select code.
  assign codeMatch = pin[wcs_pkg::PIN_SEL_LSB +: 6] == selectCode;
  assign t3Pulse = pin[wcs_pkg::PIN_T3] && !pinPrev[wcs_pkg::PIN_T3];
  assign t5Pulse = pin[wcs_pkg::PIN_T5] && !pinPrev[wcs_pkg::PIN_T5];
  assign presetEvent = pin[wcs_pkg::PIN_PRESET] && t5Pulse;
  assign setFlagEvent = pin[wcs_pkg::PIN_SETFLAG] && codeMatch && t3Pulse;
  assign clearFlagEvent = pin[wcs_pkg::PIN_CLRFLAG] && codeMatch && t3Pulse;
  assign setControlEvent = pin[wcs_pkg::PIN_SETCTL] && codeMatch
                           && t3Pulse;
  assign clearControlEvent = pin[wcs_pkg::PIN_CLRCTL] && codeMatch
                             && t3Pulse;
  assign outputActive = pin[wcs_pkg::PIN_OUT] && codeMatch;
  assign inputActive = pin[wcs_pkg::PIN_IN] && codeMatch;
  assign strobeEvent = (outputActive || inputActive) && t3Pulse;

  // ----------------------------------------------------------------
  // Direction, toggle, control and service request
  // ----------------------------------------------------------------
  // preset sets direction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      directionFf <= 1'b1;
    end else if (presetEvent || setFlagEvent) begin
      directionFf <= 1'b1;
    end else if (toggleFf && t5Pulse) begin
      directionFf <= !directionFf;
    end
  end

  // input and output strobes toggle
  // Set at T3 and spent at the T5 that ends the strobe.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      toggleFf <= 1'b0;
    end else if (strobeEvent) begin
      toggleFf <= 1'b1;
    end else if (t5Pulse) begin
      toggleFf <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      controlFf <= 1'b0;
    end else if (setControlEvent) begin
      controlFf <= 1'b1;
    end else if (clearControlEvent || presetEvent) begin
      controlFf <= 1'b0;
    end
  end

  // back to back requests
  // The set wins over any clear that lands in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serviceRequestFf <= 1'b0;
    end else if (clearFlagEvent) begin
      serviceRequestFf <= 1'b1;
    end else if (presetEvent || setFlagEvent || clearControlEvent) begin
      serviceRequestFf <= 1'b0;
    end
  end

  // The request pin is the flip-flop itself.
  assign serviceRequest = serviceRequestFf;

  // ----------------------------------------------------------------
  // Load path
  // ----------------------------------------------------------------
  logic [7:0] ramAddress;
  logic [23:0] dataReg;
  logic ramWrite;
  logic [23:0] ioReadWord;

  // first and second word latch
  // Bus data is taken at T5, while the strobe is still seen high.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ramAddress <= 8'h00;
      dataReg <= 24'h000000;
    end else if (outputActive && t5Pulse) begin
      if (directionFf) begin
        ramAddress <= pin[wcs_pkg::PIN_BUS_LSB + 8 +: 8];
        dataReg[23:16] <= pin[wcs_pkg::PIN_BUS_LSB +: 8];
      end else begin
        dataReg[15:0] <= pin[wcs_pkg::PIN_BUS_LSB +: 16];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      writePending <= 1'b0;
    end else if (setControlEvent) begin
      writePending <= 1'b1;
    end else if (t5Pulse) begin
      writePending <= 1'b0;
    end
  end

  assign ramWrite = writePending && t5Pulse;

  writable_store_ram uStore (
    .clk(clk),
    .fetchAddress(microAddress[7:0]),
    .fetchWord(fetchWord),
    .ioAddress(ramAddress),
    .ioWrite(ramWrite),
    .ioWriteWord(dataReg),
    .ioReadWord(ioReadWord)
  );

  // ----------------------------------------------------------------
  // Readback drive
  // ----------------------------------------------------------------
  // readback halves
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ioBusOut <= 16'h0000;
      ioBusDrive <= 1'b0;
    end else if (inputActive) begin
      ioBusOut <= directionFf ? {8'h00, ioReadWord[23:16]}
                              : ioReadWord[15:0];
      ioBusDrive <= 1'b1;
    end else begin
      ioBusOut <= 16'h0000;
      ioBusDrive <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Latency of the fetch pipeline stays inside the access time.
  localparam bit FETCH_LATENCY_OK =
    wcs_pkg::FETCH_LATENCY <= wcs_pkg::FETCH_ACCESS_CYCLES;

  // Fetch hit, then the delayed hit one cycle later.
  sequence fetchPath;
    fetchHit ##1 fetchHitDelayed;
  endsequence

  fetch_word_a: assert property (fetchPath |=>
    microwordLines == $past(fetchWord))
    else $error("fetched word not presented");
  fetch_time_a: assert property (fetchHit |-> ##2
    FETCH_LATENCY_OK && microwordLines == $past(fetchWord))
    else $error("fetch slower than access time");
  idle_zero_a: assert property (!fetchHit |-> ##2
    microwordLines == 24'h000000)
    else $error("lines driven while not selected");
  decode_a: assert property (microAddress[9:8] != selector |-> ##2
    microwordLines == 24'h000000)
    else $error("fetch enabled on wrong module");
  inhibit_a: assert property (##1 moduleZeroInhibit ==
    $past(moduleZeroOverride && selector == 2'h0))
    else $error("module zero inhibit wrong");
  preset_a: assert property (presetEvent && !clearFlagEvent
    |=> directionFf && !serviceRequestFf)
    else $error("preset did not initialise");
  flag_keep_a: assert property (clearFlagEvent |=>
    serviceRequest)
    else $error("clear-flag lost the request");
  ctl_clear_a: assert property (clearControlEvent
    && !clearFlagEvent |=> !serviceRequest)
    else $error("clear-control kept the request");
  dir_flip_a: assert property (toggleFf && t5Pulse
    && !presetEvent |=> directionFf != $past(directionFf))
    else $error("direction did not toggle");
  first_load_a: assert property (outputActive && t5Pulse
    && directionFf |=>
    ramAddress == $past(pin[wcs_pkg::PIN_BUS_LSB + 8 +: 8]))
    else $error("address not latched");
  foreign_code_a: assert property (!codeMatch && !presetEvent
    |=> $stable({directionFf, serviceRequestFf, controlFf, dataReg}))
    else $error("foreign code changed state");
  drive_gate_a: assert property (ioBusDrive |->
    $past(inputActive))
    else $error("bus driven without strobe");

endmodule : writable_store

// ### io_host_model.sv
// Host model: processor I/O bus that issues one strobe cycle at a time.
`timescale 1ns/1ns

module io_host_model (
  input wire logic clk,
  output logic [6:0] strobes,
  output logic phaseT3,
  output logic phaseT5,
  output logic [5:0] ioSelectCode,
  output logic [15:0] ioBusIn,
  input wire logic [15:0] ioBusOut,
  input wire logic ioBusDrive
);
  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  // Idle lines carry inverted junk so stale data is never reused.
  initial begin
    strobes = 7'h00;
    phaseT3 = 1'b0;
    phaseT5 = 1'b0;
    ioSelectCode = 6'h3F;
    ioBusIn = 16'hFFFF;
  end

  // ---------------------------------------------------------------
  // One I/O instruction
  // ---------------------------------------------------------------
  // host sequence: caller issues the steps and word halves.
  // Pins stay stable from before T3 until after T5, because the
  // block sees them through synchronisers a few cycles late.
  task automatic io_op(input logic [6:0] s, input logic [5:0] code,
    input logic [15:0] data, output logic [16:0] rd);
    strobes <= s;
    ioSelectCode <= code;
    ioBusIn <= data;
    repeat (6) @(posedge clk);
    phaseT3 <= 1'b1;
    repeat (6) @(posedge clk);
    phaseT3 <= 1'b0;
    repeat (6) @(posedge clk);
    // Bus is read before T5 so the direction has not flipped yet.
    rd = {ioBusDrive, ioBusOut};
    phaseT5 <= 1'b1;
    repeat (6) @(posedge clk);
    phaseT5 <= 1'b0;
    repeat (6) @(posedge clk);
    strobes <= 7'h00;
    ioSelectCode <= ~code;
    ioBusIn <= ~data;
    @(posedge clk);
  endtask : io_op
endmodule : io_host_model

// ### testbench.sv
// Self-checking bench for the writable microcode store.
`timescale 1ns/1ns

module testbench;
  // ---------------------------------------------------------------
  // Strobe codes, select codes and signals
  // ---------------------------------------------------------------
  localparam logic [6:0] PRE = 7'h40;
  localparam logic [6:0] SETF = 7'h20;
  localparam logic [6:0] CLRF = 7'h10;
  localparam logic [6:0] SETC = 7'h08;
  localparam logic [6:0] CLRC = 7'h04;
  localparam logic [6:0] OUTS = 7'h02;
  localparam logic [6:0] INS = 7'h01;
  localparam logic [5:0] MYC = 6'h2C;
  localparam logic [5:0] FOE = 6'h0B;
  logic clk = 1'b0, reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, moduleZeroInhibit, ioBusDrive, serviceRequest;
  logic [9:0] microAddress = 10'h000;
  logic [23:0] microwordLines;
  logic [6:0] strobes;
  logic phaseT3, phaseT5;
  logic [5:0] ioSelectCode;
  logic [15:0] ioBusIn, ioBusOut;
  logic [23:0] mem [256];
  logic [7:0] used [$];
  logic [1:0] sel = 2'h0;
  logic ovr = 1'b0;
  // Expected control flip-flop: set-control leaves it set until cleared.
  logic ctlExp = 1'b0;
  int miscompares = 0, n_compared = 0, cycles = 0;

  writable_store writable_store_inst (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .microAddress(microAddress),
    .microwordLines(microwordLines),
    .moduleZeroInhibit(moduleZeroInhibit),
    .powerOnIoPreset(strobes[6]), .setFlagStrobe(strobes[5]),
    .clearFlagStrobe(strobes[4]), .setControlStrobe(strobes[3]),
    .clearControlStrobe(strobes[2]), .outputStrobe(strobes[1]),
    .inputStrobe(strobes[0]), .phaseT3(phaseT3), .phaseT5(phaseT5),
    .ioSelectCode(ioSelectCode), .ioBusIn(ioBusIn),
    .ioBusOut(ioBusOut), .ioBusDrive(ioBusDrive),
    .serviceRequest(serviceRequest));

  io_host_model io_host_model_inst (.clk(clk), .strobes(strobes),
    .phaseT3(phaseT3), .phaseT5(phaseT5), .ioSelectCode(ioSelectCode),
    .ioBusIn(ioBusIn), .ioBusOut(ioBusOut), .ioBusDrive(ioBusDrive));

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  // Hang guard: the run needs well under a tenth of this ceiling.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      miscompares++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; called just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    // Every transfer has exactly one access cycle.
    check(n, 32'h00000001);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Status bits direction, control and request, masked.
  task automatic stat(input logic [31:0] e);
    logic [31:0] r;
    logic x;
    apb(1'b0, 8'h04, 32'h0, r, x);
    check(r & 32'h0D, e);
  endtask : stat

  // Expected masked status from direction, request and tracked control.
  function automatic logic [31:0] st(input logic d, input logic s);
    return {28'h0000000, s, ctlExp, 1'b0, d};
  endfunction : st

  task automatic cfg(input logic [1:0] s, input logic o);
    logic [31:0] r;
    logic x;
    sel = s;
    ovr = o;
    apb(1'b1, 8'h00, {18'h0, MYC, 5'h0, o, s}, r, x);
    apb(1'b0, 8'h00, 32'h0, r, x);
    check(r, {18'h0, MYC, 5'h0, o, s});
  endtask : cfg

  // Program-controlled load of one word.
  task automatic load(input logic [7:0] a, input logic [23:0] w);
    logic [16:0] q;
    io_host_model_inst.io_op(SETF, MYC, 16'h0, q);
    io_host_model_inst.io_op(OUTS, MYC, {a, w[23:16]}, q);
    stat(st(1'b0, 1'b0));
    check(q[16], 1'b0);
    io_host_model_inst.io_op(OUTS, MYC, w[15:0], q);
    io_host_model_inst.io_op(SETC, MYC, 16'h0, q);
    ctlExp = 1'b1;
    stat(32'h05);
    mem[a] = w;
    used.push_back(a);
  endtask : load

  // Readback of one word in two input transfers.
  task automatic rback(input logic [7:0] a);
    logic [16:0] q;
    io_host_model_inst.io_op(SETF, MYC, 16'h0, q);
    io_host_model_inst.io_op(OUTS, MYC, {a, 8'h00}, q);
    io_host_model_inst.io_op(SETF, MYC, 16'h0, q);
    io_host_model_inst.io_op(INS, MYC, 16'h0, q);
    check(q, {1'b1, 8'h00, mem[a][23:16]});
    io_host_model_inst.io_op(INS, MYC, 16'h0, q);
    check(q, {1'b1, mem[a][15:0]});
    repeat (8) @(posedge clk);
    check(ioBusDrive, 1'b0);
  endtask : rback

  function automatic logic [23:0] fexp(input logic [9:0] a);
    if ((sel == 2'h0 && !ovr) || a[9:8] != sel) return 24'h0;
    return mem[a[7:0]];
  endfunction : fexp

  // Pipelined fetch stream, a new address every cycle.
  task automatic fetch_run(input int n);
    logic [9:0] h [$];
    logic [9:0] a;
    for (int i = 0; i < n; i++) begin
      a[7:0] = used[$urandom % used.size()];
      a[9:8] = ($urandom % 2) ? sel : 2'($urandom);
      h.push_back(a);
      microAddress <= a;
      @(posedge clk);
      if (i >= 2) check(microwordLines, fexp(h[i - 2]));
    end
    check(moduleZeroInhibit, sel == 2'h0 && ovr);
  endtask : fetch_run

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    logic [16:0] q;
    logic [23:0] w;
    logic [7:0] a;
    void'($urandom(83053));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0, r, e);
    check(r, {18'h0, wcs_pkg::SELECT_CODE_RESET, 8'h00});
    stat(32'h01);
    apb(1'b0, 8'h08, 32'h0, r, e);
    check(r, 32'h00000000);
    check(e, 1'b1);
    $display("test reset done");
    cfg(2'h1, 1'b0);
    load(8'h00, 24'($urandom));
    load(8'hFF, 24'($urandom));
    for (int i = 0; i < 3; i++) load(8'($urandom), 24'($urandom));
    $display("test load done");
    // DMA block: each word cycle also carries clear-flag.
    a = 8'($urandom);
    w = 24'($urandom);
    io_host_model_inst.io_op(SETF, MYC, 16'h0, q);
    stat(st(1'b1, 1'b0));
    io_host_model_inst.io_op(OUTS | CLRF, MYC, {a, w[23:16]}, q);
    check(serviceRequest, 1'b1);
    io_host_model_inst.io_op(OUTS | CLRF, MYC, w[15:0], q);
    stat(st(1'b1, 1'b1));
    io_host_model_inst.io_op(CLRC, MYC, 16'h0, q);
    ctlExp = 1'b0;
    stat(32'h01);
    io_host_model_inst.io_op(SETC, MYC, 16'h0, q);
    ctlExp = 1'b1;
    mem[a] = w;
    used.push_back(a);
    $display("test dma done");
    io_host_model_inst.io_op(OUTS, FOE, {used[0], 8'h55}, q);
    io_host_model_inst.io_op(CLRF, FOE, 16'h0, q);
    io_host_model_inst.io_op(INS, FOE, 16'h0, q);
    check(q[16], 1'b0);
    io_host_model_inst.io_op(SETC, FOE, 16'h0, q);
    stat(32'h05);
    $display("test foreign done");
    cfg(2'h1, 1'b0);
    fetch_run(40);
    cfg(2'h3, 1'b0);
    fetch_run(40);
    cfg(2'h0, 1'b1);
    fetch_run(40);
    cfg(2'h0, 1'b0);
    fetch_run(40);
    $display("test fetch done");
    foreach (used[i]) rback(used[i]);
    $display("test readback done");
    io_host_model_inst.io_op(OUTS, MYC, {used[0], 8'h00}, q);
    io_host_model_inst.io_op(CLRF, MYC, 16'h0, q);
    stat(st(1'b0, 1'b1));
    io_host_model_inst.io_op(PRE, FOE, 16'h0, q);
    ctlExp = 1'b0;
    stat(32'h01);
    $display("test preset done");
    end_sim();
  end
endmodule : testbench
